// ### design/dam_top.v
// Default memory attribute map with access ordering and barrier sequencer.
// Assumes one core request at a time and tagged completions from the bus.
`timescale 1ns/1ps
`default_nettype none
`include "dam_defines.vh"

module dam_top #(
  parameter CACHE_PRESENT = 1,
  parameter OUT_W         = `DAM_OUT_W
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        big_endian,
  input  wire        core_req_valid,
  input  wire [31:0] core_req_addr,
  input  wire        core_req_write,
  input  wire [1:0]  core_req_size,
  input  wire [31:0] core_req_wdata,
  input  wire        core_req_fetch,
  input  wire        core_req_spec,
  output reg         core_req_ready,
  input  wire        bar_valid,
  input  wire [1:0]  bar_kind,
  output reg         bar_ready,
  output reg         bar_done,
  output reg         exec_stall,
  output reg         refetch,
  output reg         fetch_blocked,
  output reg         spec_refused,
  input  wire        exec_valid,
  input  wire [31:0] exec_addr,
  output reg         nx_fault,
  output reg         bus_valid,
  input  wire        bus_ready,
  output reg  [31:0] bus_addr,
  output reg         bus_write,
  output reg         bus_fetch,
  output reg  [3:0]  bus_byte_en,
  output reg  [31:0] bus_wdata,
  output reg  [1:0]  bus_mem_type,
  output reg         bus_shareable,
  output reg  [1:0]  bus_cache_pol,
  output reg         bus_nx,
  output reg  [1:0]  bus_cls,
  input  wire        bus_done,
  input  wire [1:0]  bus_done_cls
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_MEMB = 4'b0010;
  localparam [3:0] S_SYNC = 4'b0100;
  localparam [3:0] S_INST = 4'b1000;
  localparam [OUT_W-1:0] CNT_ONE = {{(OUT_W-1){1'b0}}, 1'b1};
  localparam [OUT_W-1:0] CNT_MAX = {OUT_W{1'b1}};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [3:0]       state;
  reg             st_valid;
  reg [31:0]      st_addr;
  reg             st_write;
  reg [1:0]       st_size;
  reg [31:0]      st_wdata;
  reg             st_fetch;
  reg             st_spec;
  reg [OUT_W-1:0] cnt_all;
  reg [OUT_W-1:0] cnt_dev_ns;
  reg [OUT_W-1:0] cnt_dev_sh;
  reg [OUT_W-1:0] cnt_so;

  reg [3:0]       next_state;
  reg             next_st_valid;
  reg             next_bar_done;
  reg             next_refetch;
  reg             next_blocked;
  reg             next_refused;
  reg             issue;
  reg             order_hold;
  reg [1:0]       st_cls;

  wire [2:0]  st_region;
  wire [1:0]  st_mem_type;
  wire        st_nx;
  wire        st_shr;
  wire [1:0]  st_cache;
  wire        ex_nx;
  wire [3:0]  st_be;
  wire [31:0] st_lane;
  wire        st_big;
  wire        bus_busy;
  wire        take_req;
  wire        take_bar;
  wire        done_live;

  // ----------------------------------------------------------------
  // Attribute decode and byte lanes
  // ----------------------------------------------------------------
  dam_region_decode #(
    .CACHE_PRESENT (CACHE_PRESENT)
  ) u_st_decode (
    .addr      (st_addr),
    .region    (st_region),
    .mem_type  (st_mem_type),
    .nx        (st_nx),
    .shareable (st_shr),
    .cache_pol (st_cache)
  );

  dam_region_decode #(
    .CACHE_PRESENT (CACHE_PRESENT)
  ) u_ex_decode (
    .addr      (exec_addr),
    .region    (),
    .mem_type  (),
    .nx        (ex_nx),
    .shareable (),
    .cache_pol ()
  );

  // Fetches and private peripheral accesses ignore the data endianness
  assign st_big = big_endian & ~st_fetch & (st_region != `DAM_RGN_PRIV);

  dam_byte_lane u_lane (
    .size       (st_size),
    .addr_lo    (st_addr[1:0]),
    .wdata      (st_wdata),
    .big_endian (st_big),
    .byte_en    (st_be),
    .lane_data  (st_lane)
  );

  assign bus_busy  = bus_valid & ~bus_ready;
  assign take_bar  = bar_valid & bar_ready;
  assign take_req  = core_req_valid & core_req_ready & ~bar_valid;
  assign done_live = bus_done & (cnt_all != {OUT_W{1'b0}});

  // ----------------------------------------------------------------
  // Ordering and issue decision
  // ----------------------------------------------------------------
  always @*
  begin
    if (st_mem_type == `DAM_MT_STRONG)
      st_cls = `DAM_CLS_STRONG;
    else if (st_mem_type == `DAM_MT_DEVICE)
      st_cls = st_shr ? `DAM_CLS_DEV_SH : `DAM_CLS_DEV_NS;
    else
      st_cls = `DAM_CLS_NORMAL;
    order_hold = 1'b0;
    case (st_cls)
      `DAM_CLS_STRONG:
        order_hold = (cnt_so | cnt_dev_ns | cnt_dev_sh) != {OUT_W{1'b0}};
      `DAM_CLS_DEV_NS:
        order_hold = (cnt_so | cnt_dev_ns) != {OUT_W{1'b0}};
      `DAM_CLS_DEV_SH:
        order_hold = cnt_so != {OUT_W{1'b0}};
      default:
        order_hold = 1'b0;
    endcase
    next_blocked = 1'b0;
    next_refused = 1'b0;
    issue        = 1'b0;
    if (st_valid)
    begin
      if (st_fetch && st_nx)
        next_blocked = 1'b1;
      else if (st_spec && !st_fetch && st_mem_type != `DAM_MT_NORMAL)
        next_refused = 1'b1;
      else
        issue = ~bus_busy & ~order_hold & (cnt_all != CNT_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Barrier sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    next_state    = state;
    next_bar_done = 1'b0;
    next_refetch  = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (take_bar)
        begin
          case (bar_kind)
            `DAM_BAR_MEMORY: next_state = S_MEMB;
            `DAM_BAR_SYNC:   next_state = S_SYNC;
            default:         next_state = S_INST;
          endcase
        end
      end
      S_MEMB, S_SYNC:
      begin
        if (cnt_all == {OUT_W{1'b0}} || (cnt_all == CNT_ONE && done_live))
        begin
          next_state    = S_IDLE;
          next_bar_done = 1'b1;
        end
      end
      S_INST:
      begin
        next_state    = S_IDLE;
        next_bar_done = 1'b1;
        next_refetch  = 1'b1;
      end
      default:
        next_state = S_IDLE;
    endcase
    next_st_valid = take_req | (st_valid & ~issue & ~next_blocked & ~next_refused);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state          <= S_IDLE;
      st_valid       <= 1'b0;
      st_addr        <= 32'h00000000;
      st_write       <= 1'b0;
      st_size        <= `DAM_SZ_BYTE;
      st_wdata       <= 32'h00000000;
      st_fetch       <= 1'b0;
      st_spec        <= 1'b0;
      core_req_ready <= 1'b0;
      bar_ready      <= 1'b0;
      bar_done       <= 1'b0;
      exec_stall     <= 1'b0;
      refetch        <= 1'b0;
      fetch_blocked  <= 1'b0;
      spec_refused   <= 1'b0;
      nx_fault       <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      st_valid       <= next_st_valid;
      if (take_req)
      begin
        st_addr  <= core_req_addr;
        st_write <= core_req_write;
        st_size  <= core_req_size;
        st_wdata <= core_req_wdata;
        st_fetch <= core_req_fetch;
        st_spec  <= core_req_spec;
      end
      core_req_ready <= (next_state == S_IDLE) & ~next_st_valid;
      bar_ready      <= (next_state == S_IDLE) & ~next_st_valid;
      bar_done       <= next_bar_done;
      exec_stall     <= (next_state == S_SYNC);
      refetch        <= next_refetch;
      fetch_blocked  <= next_blocked;
      spec_refused   <= next_refused;
      nx_fault       <= exec_valid & ex_nx;
    end
  end

  // ----------------------------------------------------------------
  // Bus request register and outstanding counters
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_valid     <= 1'b0;
      bus_addr      <= 32'h00000000;
      bus_write     <= 1'b0;
      bus_fetch     <= 1'b0;
      bus_byte_en   <= 4'h0;
      bus_wdata     <= 32'h00000000;
      bus_mem_type  <= `DAM_MT_NORMAL;
      bus_shareable <= 1'b0;
      bus_cache_pol <= `DAM_CP_NONE;
      bus_nx        <= 1'b0;
      bus_cls       <= `DAM_CLS_NORMAL;
      cnt_all       <= {OUT_W{1'b0}};
      cnt_dev_ns    <= {OUT_W{1'b0}};
      cnt_dev_sh    <= {OUT_W{1'b0}};
      cnt_so        <= {OUT_W{1'b0}};
    end
    else
    begin
      if (issue)
      begin
        bus_valid     <= 1'b1;
        bus_addr      <= st_addr;
        bus_write     <= st_write;
        bus_fetch     <= st_fetch;
        bus_byte_en   <= st_be;
        bus_wdata     <= st_lane;
        bus_mem_type  <= st_mem_type;
        bus_shareable <= st_shr;
        bus_cache_pol <= st_cache;
        bus_nx        <= st_nx;
        bus_cls       <= st_cls;
      end
      else if (bus_ready)
        bus_valid <= 1'b0;
      cnt_all <= cnt_all + (issue ? CNT_ONE : {OUT_W{1'b0}})
                         - (done_live ? CNT_ONE : {OUT_W{1'b0}});
      cnt_dev_ns <= cnt_dev_ns
        + ((issue && st_cls == `DAM_CLS_DEV_NS) ? CNT_ONE : {OUT_W{1'b0}})
        - ((done_live && bus_done_cls == `DAM_CLS_DEV_NS && cnt_dev_ns != {OUT_W{1'b0}})
           ? CNT_ONE : {OUT_W{1'b0}});
      cnt_dev_sh <= cnt_dev_sh
        + ((issue && st_cls == `DAM_CLS_DEV_SH) ? CNT_ONE : {OUT_W{1'b0}})
        - ((done_live && bus_done_cls == `DAM_CLS_DEV_SH && cnt_dev_sh != {OUT_W{1'b0}})
           ? CNT_ONE : {OUT_W{1'b0}});
      cnt_so <= cnt_so
        + ((issue && st_cls == `DAM_CLS_STRONG) ? CNT_ONE : {OUT_W{1'b0}})
        - ((done_live && bus_done_cls == `DAM_CLS_STRONG && cnt_so != {OUT_W{1'b0}})
           ? CNT_ONE : {OUT_W{1'b0}});
    end
  end

endmodule
`default_nettype wire

// ### shared/dam_defines.vh
// Constants for the default memory attribute map and access sequencer.
// Assumes inclusion by the design files of the dam block only.
//
// Functional notes
// - Whole 4GB space decodes to seven regions
// - Code and RAM regions: Normal, executable
// - Peripheral, external device: Device, execute-never
// - Fault only when execute-never instruction executes
// - Private peripheral range: Strongly-ordered, execute-never
// - Top range: vendor Device, execute-never
// - Cache policies: code write-through, SRAM and lower external RAM write-back allocate, upper external RAM none
// - Normal accesses may reorder, speculate reads
// - Device/Strongly-ordered kept in mutual order except shareable Device, ordered only against Strongly-ordered
// - Strongly-ordered always reported shareable
// - No ordering guarantee involving Normal access
// - Strongly-ordered pairs, non-shareable Device pairs ordered
// - Data memory barrier completes outstanding first
// - Data sync barrier stalls later instructions
// - Instruction sync barrier forces refetch
// - Big-endian: MSB at lowest byte address
// - Little-endian: LSB at lowest byte address
// - Prefetch and speculative branch-target fetch allowed
// - Fetches, private peripheral accesses always little-endian
`ifndef DAM_DEFINES_VH
`define DAM_DEFINES_VH

// ----------------------------------------------------------------
// Region codes
// ----------------------------------------------------------------
`define DAM_RGN_CODE      3'h0
`define DAM_RGN_SRAM      3'h1
`define DAM_RGN_PERIPH    3'h2
`define DAM_RGN_EXTRAM    3'h3
`define DAM_RGN_EXTDEV    3'h4
`define DAM_RGN_PRIV      3'h5
`define DAM_RGN_VENDOR    3'h6

// ----------------------------------------------------------------
// Address boundaries (top three bits, then top twelve bits)
// ----------------------------------------------------------------
`define DAM_TOP3_CODE     3'h0
`define DAM_TOP3_SRAM     3'h1
`define DAM_TOP3_PERIPH   3'h2
`define DAM_TOP3_EXTRAM_L 3'h3
`define DAM_TOP3_EXTRAM_H 3'h4
`define DAM_TOP3_EXTDEV_L 3'h5
`define DAM_TOP3_EXTDEV_H 3'h6
`define DAM_TOP12_PRIV    12'he00

// ----------------------------------------------------------------
// Memory types, cache policies, access classes
// ----------------------------------------------------------------
`define DAM_MT_NORMAL     2'h0
`define DAM_MT_DEVICE     2'h1
`define DAM_MT_STRONG     2'h2
`define DAM_CP_NONE       2'h0
`define DAM_CP_WR_THRU    2'h1
`define DAM_CP_WB_ALLOC   2'h2
`define DAM_CLS_NORMAL    2'h0
`define DAM_CLS_DEV_NS    2'h1
`define DAM_CLS_DEV_SH    2'h2
`define DAM_CLS_STRONG    2'h3

// ----------------------------------------------------------------
// Access sizes and barrier kinds
// ----------------------------------------------------------------
`define DAM_SZ_BYTE       2'h0
`define DAM_SZ_HALF       2'h1
`define DAM_SZ_WORD       2'h2
`define DAM_BAR_MEMORY    2'h0
`define DAM_BAR_SYNC      2'h1
`define DAM_BAR_INSTR     2'h2

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define DAM_OUT_W         4

`endif

// ### design/dam_region_decode.v
// Combinational address to region attribute decoder.
// Assumes a 32-bit byte address; no override from a protection unit.
`timescale 1ns/1ps
`default_nettype none
`include "dam_defines.vh"

module dam_region_decode #(
  parameter CACHE_PRESENT = 1
) (
  input  wire [31:0] addr,
  output reg  [2:0]  region,
  output reg  [1:0]  mem_type,
  output reg         nx,
  output reg         shareable,
  output reg  [1:0]  cache_pol
);

  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  always @*
  begin
    region    = `DAM_RGN_VENDOR;
    mem_type  = `DAM_MT_DEVICE;
    nx        = 1'b1;
    shareable = 1'b0;
    cache_pol = `DAM_CP_NONE;
    case (addr[31:29])
      `DAM_TOP3_CODE:
      begin
        region   = `DAM_RGN_CODE;
        mem_type = `DAM_MT_NORMAL;
        nx       = 1'b0;
        if (CACHE_PRESENT != 0)
          cache_pol = `DAM_CP_WR_THRU;
      end
      `DAM_TOP3_SRAM:
      begin
        region   = `DAM_RGN_SRAM;
        mem_type = `DAM_MT_NORMAL;
        nx       = 1'b0;
        if (CACHE_PRESENT != 0)
          cache_pol = `DAM_CP_WB_ALLOC;
      end
      `DAM_TOP3_PERIPH:
        region = `DAM_RGN_PERIPH;
      `DAM_TOP3_EXTRAM_L, `DAM_TOP3_EXTRAM_H:
      begin
        region   = `DAM_RGN_EXTRAM;
        mem_type = `DAM_MT_NORMAL;
        nx       = 1'b0;
        if (CACHE_PRESENT != 0 && addr[31:29] == `DAM_TOP3_EXTRAM_L)
          cache_pol = `DAM_CP_WB_ALLOC;
      end
      `DAM_TOP3_EXTDEV_L, `DAM_TOP3_EXTDEV_H:
        region = `DAM_RGN_EXTDEV;
      default:
      begin
        if (addr[31:20] == `DAM_TOP12_PRIV)
        begin
          region    = `DAM_RGN_PRIV;
          mem_type  = `DAM_MT_STRONG;
          shareable = 1'b1;
        end
        else
          region = `DAM_RGN_VENDOR;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### design/dam_byte_lane.v
// Write data byte-lane steering with configurable data endianness.
// Assumes naturally aligned accesses on a 32-bit little-numbered bus.
`timescale 1ns/1ps
`default_nettype none
`include "dam_defines.vh"

module dam_byte_lane (
  input  wire [1:0]  size,
  input  wire [1:0]  addr_lo,
  input  wire [31:0] wdata,
  input  wire        big_endian,
  output reg  [3:0]  byte_en,
  output reg  [31:0] lane_data
);

  reg [31:0] ordered;
  reg [3:0]  mask;

  // ----------------------------------------------------------------
  // Byte order then lane shift
  // ----------------------------------------------------------------
  always @*
  begin
    ordered = wdata;
    mask    = 4'h1;
    case (size)
      `DAM_SZ_HALF:
      begin
        mask = 4'h3;
        if (big_endian)
          ordered = {16'h0000, wdata[7:0], wdata[15:8]};
      end
      `DAM_SZ_WORD:
      begin
        mask = 4'hf;
        if (big_endian)
          ordered = {wdata[7:0], wdata[15:8], wdata[23:16], wdata[31:24]};
      end
      default:
        mask = 4'h1;
    endcase
    lane_data = ordered << {addr_lo, 3'b000};
    byte_en   = mask << addr_lo;
  end

endmodule
`default_nettype wire

// ### verif/dam_checker.sv
// Assertions on the attribute and ordering outputs of dam_top.
// Assumes binding into dam_top; one ref_clk domain, arst_n active low.
`timescale 1ns/1ps
`default_nettype none
module dam_checker (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        refetch,
  input wire logic        bar_done,
  input wire logic        exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic        nx_fault,
  input wire logic        bus_valid,
  input wire logic        bus_ready,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_fetch,
  input wire logic [1:0]  bus_mem_type,
  input wire logic        bus_shareable,
  input wire logic        bus_nx,
  input wire logic [1:0]  bus_cls,
  input wire logic        bus_done,
  input wire logic [1:0]  bus_done_cls
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // --------------------------------------------------------------
  // Outstanding transfers per ordering class
  // --------------------------------------------------------------
  logic [4:0] n_dn;
  logic [4:0] n_ds;
  logic [4:0] n_so;
  wire logic  acc = bus_valid && bus_ready;
  wire logic  xa = exec_addr[31:29] == 3'h2 || exec_addr[31:29] >= 3'h5;

  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      n_dn <= 5'h00;
      n_ds <= 5'h00;
      n_so <= 5'h00;
    end
    else
    begin
      n_dn <= n_dn + 5'(acc && bus_cls == 2'h1) - 5'(bus_done && bus_done_cls == 2'h1 && n_dn != 0);
      n_ds <= n_ds + 5'(acc && bus_cls == 2'h2) - 5'(bus_done && bus_done_cls == 2'h2 && n_ds != 0);
      n_so <= n_so + 5'(acc && bus_cls == 2'h3) - 5'(bus_done && bus_done_cls == 2'h3 && n_so != 0);
    end

  property p_fault_cause; nx_fault |-> $past(exec_valid && xa); endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("stray fault");
  property p_fault_given; exec_valid && xa |=> nx_fault; endproperty
  a_fault_given: assert property (p_fault_given) else $error("fault missing");
  property p_no_nx_fetch; bus_valid |-> !(bus_fetch && bus_nx); endproperty
  a_no_nx_fetch: assert property (p_no_nx_fetch) else $error("blocked fetch issued");
  property p_so_share; bus_valid && bus_mem_type == 2'h2 |-> bus_shareable; endproperty
  a_so_share: assert property (p_so_share) else $error("ordered not shareable");
  property p_priv_range;
    bus_valid && bus_addr[31:20] == 12'he00 |-> bus_mem_type == 2'h2 && bus_nx;
  endproperty
  a_priv_range: assert property (p_priv_range) else $error("private range attributes");
  property p_hold;
    bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr) && $stable(bus_cls);
  endproperty
  a_hold: assert property (p_hold) else $error("transfer dropped");
  property p_so_order; bus_valid && bus_cls == 2'h3 |-> n_dn + n_ds + n_so == 0; endproperty
  a_so_order: assert property (p_so_order) else $error("ordered issued early");
  property p_dns_order; bus_valid && bus_cls == 2'h1 |-> n_dn + n_so == 0; endproperty
  a_dns_order: assert property (p_dns_order) else $error("device issued early");
  property p_refetch; refetch |-> bar_done; endproperty
  a_refetch: assert property (p_refetch) else $error("refetch off barrier");
endmodule
bind dam_top dam_checker u_chk (.*);
`default_nettype wire

// ### verif/dam_bus_model.sv
// Bus partner: accepts issued transfers, reports completions later.
// Assumes one ref_clk domain; slow adds stalls and late completions.
`timescale 1ns/1ps
`default_nettype none
module dam_bus_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       slow,
  input  wire logic       bus_valid,
  input  wire logic [1:0] bus_cls,
  output logic            bus_ready,
  output logic            bus_done,
  output logic [1:0]      bus_done_cls
);
  logic [1:0] q [$];
  logic [2:0] gap;

  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      q.delete();
      bus_ready <= 1'b0;
      bus_done <= 1'b0;
      bus_done_cls <= 2'h0;
      gap <= 3'h0;
    end
    else
    begin
      bus_ready <= slow ? !bus_ready : 1'b1;
      if (q.size() != 0 && (gap == 3'h0 || q[0] == 2'h3))
      begin
        bus_done <= 1'b1;
        bus_done_cls <= q[0];
        gap <= slow ? 3'h5 : 3'h1;
        void'(q.pop_front());
      end
      else
      begin
        bus_done <= 1'b0;
        bus_done_cls <= ~bus_done_cls;
        gap <= gap == 3'h0 ? 3'h0 : gap - 3'h1;
      end
      if (bus_valid && bus_ready)
        q.push_back(bus_cls);
    end
endmodule
`default_nettype wire

// ### verif/dam_tb.sv
// Self-checking bench: dam_top against a reference model and bus partner.
// Assumes dam_checker bound into dam_top and dam_bus_model beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        big_endian = 1'b0;
  logic        slow = 1'b0;
  logic        core_req_valid = 1'b0;
  logic [31:0] core_req_addr = 32'h0;
  logic        core_req_write = 1'b0;
  logic [1:0]  core_req_size = 2'h0;
  logic [31:0] core_req_wdata = 32'h0;
  logic        core_req_fetch = 1'b0;
  logic        core_req_spec = 1'b0;
  logic        bar_valid = 1'b0;
  logic [1:0]  bar_kind = 2'h0;
  logic        exec_valid = 1'b0;
  logic [31:0] exec_addr = 32'h0;
  wire logic   core_req_ready, bar_ready, bar_done, exec_stall, refetch;
  wire logic   fetch_blocked, spec_refused, nx_fault, bus_valid, bus_ready;
  wire logic   bus_write, bus_fetch, bus_shareable, bus_nx, bus_done;
  wire logic [31:0] bus_addr, bus_wdata;
  wire logic [3:0]  bus_byte_en;
  wire logic [1:0]  bus_mem_type, bus_cache_pol, bus_cls, bus_done_cls;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [15:0] seed = 16'h0015;
  logic [31:0] adr [9] = '{32'h0000_0004, 32'h2000_0000, 32'h4000_0008, 32'h6000_0000,
                           32'h8000_0000, 32'ha000_0000, 32'he000_0000, 32'he010_0000,
                           32'hffff_fffc};

  dam_top uut (.*);
  dam_bus_model bm (.*);
  always #20 ref_clk = ~ref_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Packed as type, shareable, policy, execute-never, class
  function automatic logic [7:0] attr(input logic [31:0] a);
    case (a[31:29])
      3'h0: return 8'h08;
      3'h1, 3'h3: return 8'h10;
      3'h4: return 8'h00;
      3'h7: return a[31:20] == 12'he00 ? 8'ha7 : 8'h45;
      default: return 8'h45;
    endcase
  endfunction

  function automatic logic [31:0] keep(input logic [31:0] v, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (!m[i])
        v[8*i+:8] = 8'h00;
    return v;
  endfunction

  function automatic logic [35:0] lanes(input logic [31:0] a, d, input logic [1:0] sz,
                                        input logic be);
    logic [3:0]  m;
    logic [31:0] v;
    m = sz == 2'h2 ? 4'hf : sz == 2'h1 ? 4'h3 : 4'h1;
    v = d;
    if (be && sz == 2'h2)
      v = {d[7:0], d[15:8], d[23:16], d[31:24]};
    if (be && sz == 2'h1)
      v = {16'h0000, d[7:0], d[15:8]};
    m = m << a[1:0];
    v = v << (8 * a[1:0]);
    return {m, keep(v, m)};
  endfunction

  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wflag(input int k, output logic hit);
    hit = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      case (k)
        0: hit |= fetch_blocked;
        1: hit |= spec_refused;
        default: hit |= nx_fault;
      endcase
    end
  endtask

  task automatic req(input logic [31:0] a, input logic w, f, s, input logic [1:0] sz);
    logic [7:0]  e;
    logic [35:0] l;
    logic        hit;
    int          n;
    seed = lfsr(seed);
    e = attr(a);
    l = lanes(a, {seed, ~seed}, sz, big_endian && !f && a[31:20] != 12'he00);
    @(negedge ref_clk);
    core_req_valid = 1'b1;
    core_req_addr = a;
    core_req_write = w;
    core_req_size = sz;
    core_req_wdata = {seed, ~seed};
    core_req_fetch = f;
    core_req_spec = s;
    n = 0;
    do
      @(posedge ref_clk);
    while (core_req_ready !== 1'b1 && ++n < 50);
    @(negedge ref_clk);
    core_req_valid = 1'b0;
    if (f && e[2])
    begin
      wflag(0, hit);
      chk(hit, 1'b1);
    end
    else if (s && !f && !w && e[7:6] != 2'h0)
    begin
      wflag(1, hit);
      chk(hit, 1'b1);
    end
    else
    begin
      n = 0;
      do
        @(posedge ref_clk);
      while (!(bus_valid === 1'b1 && bus_ready === 1'b1) && ++n < 50);
      chk(bus_addr, a);
      chk({bus_mem_type, bus_shareable, bus_cache_pol, bus_nx, bus_cls}, e);
      chk(bus_byte_en, l[35:32]);
      if (w)
        chk(keep(bus_wdata, bus_byte_en), l[31:0]);
      chk(bus_fetch, f);
      chk(bus_write, w);
    end
  endtask

  task automatic bar(input logic [1:0] k);
    logic st;
    int   n;
    @(negedge ref_clk);
    bar_valid = 1'b1;
    bar_kind = k;
    n = 0;
    do
      @(posedge ref_clk);
    while (bar_ready !== 1'b1 && ++n < 50);
    @(negedge ref_clk);
    bar_valid = 1'b0;
    st = 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      st |= exec_stall;
    end
    while (bar_done !== 1'b1 && ++n < 80);
    chk(bar_done, 1'b1);
    if (k != 2'h2)
      chk(bm.q.size(), 0);
    chk(st, k == 2'h1);
    chk(refetch, k == 2'h2);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    logic       hit;
    logic [7:0] e;
    logic [1:0] o;
    repeat (3)
      @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2)
      @(posedge ref_clk);
    for (int m = 0; m < 2; m++)
    begin
      @(negedge ref_clk);
      big_endian = m[0];
      slow = m[0];
      foreach (adr[i])
      begin
        for (int sz = 0; sz < 3; sz++)
        begin
          seed = lfsr(seed);
          o = seed[3:2] & ~((2'h1 << sz) - 2'h1);
          req(adr[i] + o, 1'b1, 1'b0, 1'b0, sz[1:0]);
        end
        req(adr[i], 1'b0, 1'b1, m[0], 2'h2);
        req(adr[i], 1'b0, 1'b0, 1'b1, 2'h2);
        e = attr(adr[i]);
        @(negedge ref_clk);
        exec_valid = 1'b1;
        exec_addr = adr[i];
        @(negedge ref_clk);
        exec_valid = 1'b0;
        wflag(2, hit);
        chk(hit, e[2]);
      end
      bar(2'h0);
      req(32'h4000_0000, 1'b1, 1'b0, 1'b0, 2'h2);
      bar(2'h1);
      bar(2'h2);
    end
    close_out();
  end
endmodule
`default_nettype wire
